// [hdl/mcu_ctrl_regs.vh]
`ifndef MCU_CTRL_REGS_VH
`define MCU_CTRL_REGS_VH

// ----------------------------------------------------------
// Fixed codes
// ----------------------------------------------------------
`define OP_NO_OP 14'h0000
`define OP_RESET 14'h0001
`define OP_RETURN 14'h0008
`define OP_IRQ_RETURN 14'h0009
`define OP_CALL_ACC 14'h000A
`define OP_REL_BRANCH_ACC 14'h000B
`define OP_SLEEP 14'h0063
`define OP_KICK 14'h0064

// ----------------------------------------------------------
// Prefix codes, compared against the top bits
// ----------------------------------------------------------
`define PFX_REL_BRANCH 5'h19
`define PFX_CALL 3'h4
`define PFX_JUMP 3'h5
`define PFX_RET_LIT 6'h34
`define PFX_LIT_AND 6'h39
`define PFX_LIT_ADD 6'h3E
`define PFX_REG_AND 6'h05
`define PFX_PADD 7'h62
`define PFX_LDIDX 7'h7E
`define PFX_STIDX 7'h7F
`define PFX_DIR 11'h00C
`define PFX_LDIND 11'h002
`define PFX_STIND 11'h003

// ----------------------------------------------------------
// Widths, field positions and reset values
// ----------------------------------------------------------
`define PC_W 15
`define STACK_DEPTH 16
`define SLOW_BIT 15
`define PC_RESET 15'h0000
`define PTR_RESET 16'h0000
`define ACC_RESET 8'h00
`define DIR_RESET 8'hFF

`endif

// [hdl/mcu_control_indirect_op_decoder.v]
`timescale 1ns/1ps
`include "mcu_ctrl_regs.vh"

module mcu_control_indirect_op_decoder
(
   // Clock, reset, enable
   input wire sys_clk,
   input wire sys_rst,
   input wire clk_en,
   // Instruction fetch
   output reg [14:0] program_counter,
   input wire [13:0] instr_word,
   input wire [6:0] pc_latch_hi,
   // Data memory
   input wire [5:0] bank_sel,
   output reg [15:0] mem_addr,
   output reg mem_rd,
   output reg mem_wr,
   output reg [7:0] mem_wdata,
   input wire [7:0] mem_rdata,
   // Core state
   output reg [7:0] acc,
   output reg [15:0] ptr0,
   output reg [15:0] ptr1,
   output reg carry_flag,
   output reg digit_carry_flag,
   output reg zero_flag,
   output reg timeout_flag,
   output reg powerdown_flag,
   output reg [63:0] pin_direction_reg,
   // System events
   output reg standby,
   input wire wake_pin,
   output reg soft_reset_req,
   output reg watchdog_clear,
   output reg irq_enable_set,
   output wire busy
);

   // ----------------------------------------------------------
   // States
   // ----------------------------------------------------------
   localparam [3:0] ST_RUN = 4'b0001;
   localparam [3:0] ST_STRETCH = 4'b0010;
   localparam [3:0] ST_FLUSH = 4'b0100;
   localparam [3:0] ST_SLEEP = 4'b1000;

   // ----------------------------------------------------------
   // Functions
   // ----------------------------------------------------------
   function [15:0] sext6;
      input [5:0] k;
      begin
         sext6 = {{10{k[5]}}, k};
      end
   endfunction

   // Pre forms (mm = 00/01) move the pointer before use
   function [15:0] modified_ptr;
      input [15:0] p;
      input [1:0] mm;
      begin
         case (mm)
            2'b00: modified_ptr = p + 16'h0001;
            2'b01: modified_ptr = p - 16'h0001;
            2'b10: modified_ptr = p + 16'h0001;
            default: modified_ptr = p - 16'h0001;
         endcase
      end
   endfunction

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   reg [3:0] state;
   reg [14:0] stack [0:15];
   reg [3:0] sp;
   reg wake_meta;
   reg wake_sync;
   integer i;

   // ----------------------------------------------------------
   // Decode
   // ----------------------------------------------------------
   wire is_rel_branch = instr_word[13:9] == `PFX_REL_BRANCH;
   wire is_rel_branch_acc = instr_word == `OP_REL_BRANCH_ACC;
   wire is_call = instr_word[13:11] == `PFX_CALL;
   wire is_jump = instr_word[13:11] == `PFX_JUMP;
   wire is_call_acc = instr_word == `OP_CALL_ACC;
   wire is_irq_return = instr_word == `OP_IRQ_RETURN;
   wire is_return = instr_word == `OP_RETURN;
   wire is_return_literal = instr_word[13:8] == `PFX_RET_LIT;
   wire is_reset = instr_word == `OP_RESET;
   wire is_sleep = instr_word == `OP_SLEEP;
   wire is_kick = instr_word == `OP_KICK;
   // Fixed codes inside the selector range take priority
   wire is_dir_load = instr_word[13:3] == `PFX_DIR && !is_sleep && !is_kick;
   wire is_padd = instr_word[13:7] == `PFX_PADD;
   wire is_ldind = instr_word[13:3] == `PFX_LDIND;
   wire is_stind = instr_word[13:3] == `PFX_STIND;
   wire is_ldidx = instr_word[13:7] == `PFX_LDIDX;
   wire is_stidx = instr_word[13:7] == `PFX_STIDX;
   wire is_literal_and = instr_word[13:8] == `PFX_LIT_AND;
   wire is_literal_add = instr_word[13:8] == `PFX_LIT_ADD;
   wire is_register_and = instr_word[13:8] == `PFX_REG_AND;

   wire [1:0] mm = instr_word[1:0];
   wire n_ind = instr_word[2];
   wire n_idx = instr_word[6];
   wire [15:0] ptr_ind = n_ind ? ptr1 : ptr0;
   wire [15:0] ptr_idx = n_idx ? ptr1 : ptr0;
   wire [15:0] ptr_mod = modified_ptr(ptr_ind, mm);
   wire [6:0] f_addr = instr_word[6:0];
   wire dest_f = instr_word[7];
   wire f_indirect = f_addr[6:1] == 6'h00;

   wire [14:0] pc_next = program_counter + 15'h0001;
   wire [15:0] bra_ofs = {{7{instr_word[8]}}, instr_word[8:0]};

   // ----------------------------------------------------------
   // Data memory address and strobes
   // ----------------------------------------------------------
   always @*
   begin
      mem_addr = 16'h0000;
      mem_rd = 1'b0;
      if (is_ldind || is_stind)
      begin
         mem_addr = mm[1] ? ptr_ind : ptr_mod;
         mem_rd = is_ldind;
      end
      else if (is_ldidx || is_stidx)
      begin
         mem_addr = ptr_idx + sext6(instr_word[5:0]);
         mem_rd = is_ldidx;
      end
      else if (is_register_and)
      begin
         if (f_indirect)
            mem_addr = f_addr[0] ? ptr1 : ptr0;
         else
            mem_addr = {3'h0, bank_sel, f_addr};
         mem_rd = 1'b1;
      end
   end

   wire mem_op = is_ldind || is_stind || is_ldidx || is_stidx ||
      (is_register_and && f_indirect);
   // Upper half of the pointer space is slow memory
   wire needs_extra = mem_op && mem_addr[`SLOW_BIT];
   wire run_now = (state == ST_RUN) && !needs_extra;
   wire exec = clk_en && (run_now || state == ST_STRETCH);

   wire [7:0] and_f = acc & mem_rdata;
   wire [8:0] add_sum = {1'b0, acc} + {1'b0, instr_word[7:0]};
   wire [4:0] add_lo = {1'b0, acc[3:0]} + {1'b0, instr_word[3:0]};

   always @*
   begin
      mem_wr = 1'b0;
      mem_wdata = acc;
      if (state == ST_RUN || state == ST_STRETCH)
      begin
         if (is_stind || is_stidx)
            mem_wr = exec;
         else if (is_register_and && dest_f)
         begin
            mem_wr = exec;
            mem_wdata = and_f;
         end
      end
   end

   // A program counter change flushes the next fetch
   wire takes_branch = is_rel_branch || is_rel_branch_acc || is_call ||
      is_jump || is_call_acc || is_irq_return || is_return ||
      is_return_literal;

   assign busy = state != ST_RUN;

   // ----------------------------------------------------------
   // Wake synchroniser
   // ----------------------------------------------------------
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end
      else if (clk_en)
      begin
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
      end
   end

   // ----------------------------------------------------------
   // Execute
   // ----------------------------------------------------------
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_RUN;
         program_counter <= `PC_RESET;
         sp <= 4'h0;
         acc <= `ACC_RESET;
         ptr0 <= `PTR_RESET;
         ptr1 <= `PTR_RESET;
         carry_flag <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero_flag <= 1'b0;
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
         pin_direction_reg <= {8{`DIR_RESET}};
         standby <= 1'b0;
         soft_reset_req <= 1'b0;
         watchdog_clear <= 1'b0;
         irq_enable_set <= 1'b0;
         for (i = 0; i < `STACK_DEPTH; i = i + 1)
            stack[i] <= `PC_RESET;
      end
      else if (clk_en)
      begin
         soft_reset_req <= 1'b0;
         watchdog_clear <= 1'b0;
         irq_enable_set <= 1'b0;
         case (state)
            ST_FLUSH:
               state <= ST_RUN;
            ST_SLEEP:
               if (wake_sync)
               begin
                  standby <= 1'b0;
                  state <= ST_RUN;
               end
            ST_RUN, ST_STRETCH:
               if (state == ST_RUN && needs_extra)
                  state <= ST_STRETCH;
               else
               begin
                  state <= takes_branch ? ST_FLUSH : ST_RUN;
                  program_counter <= pc_next;
                  if (is_rel_branch)
                     program_counter <= pc_next + bra_ofs[14:0];
                  else if (is_rel_branch_acc)
                     program_counter <= pc_next + {7'h00, acc};
                  else if (is_jump)
                     program_counter <= {pc_latch_hi[6:3],
                        instr_word[10:0]};
                  else if (is_call || is_call_acc)
                  begin
                     stack[sp] <= pc_next;
                     sp <= sp + 4'h1;
                     if (is_call)
                        program_counter <= {pc_latch_hi[6:3],
                           instr_word[10:0]};
                     else
                        program_counter <= {pc_latch_hi, acc};
                  end
                  else if (is_return || is_irq_return || is_return_literal)
                  begin
                     program_counter <= stack[sp - 4'h1];
                     sp <= sp - 4'h1;
                     irq_enable_set <= is_irq_return;
                     if (is_return_literal)
                        acc <= instr_word[7:0];
                  end
                  else if (is_reset)
                     soft_reset_req <= 1'b1;
                  else if (is_kick)
                  begin
                     watchdog_clear <= 1'b1;
                     timeout_flag <= 1'b1;
                     powerdown_flag <= 1'b1;
                  end
                  else if (is_sleep)
                  begin
                     watchdog_clear <= 1'b1;
                     timeout_flag <= 1'b1;
                     powerdown_flag <= 1'b0;
                     standby <= 1'b1;
                     state <= ST_SLEEP;
                  end
                  else if (is_dir_load)
                     pin_direction_reg[instr_word[2:0]*8 +: 8] <= acc;
                  else if (is_padd)
                  begin
                     // 16-bit sum drops the carry, so it wraps
                     if (instr_word[6])
                        ptr1 <= ptr1 + sext6(instr_word[5:0]);
                     else
                        ptr0 <= ptr0 + sext6(instr_word[5:0]);
                  end
                  else if (is_ldind || is_stind)
                  begin
                     if (n_ind)
                        ptr1 <= ptr_mod;
                     else
                        ptr0 <= ptr_mod;
                     if (is_ldind)
                     begin
                        acc <= mem_rdata;
                        zero_flag <= mem_rdata == 8'h00;
                     end
                  end
                  else if (is_ldidx)
                  begin
                     acc <= mem_rdata;
                     zero_flag <= mem_rdata == 8'h00;
                  end
                  else if (is_literal_and)
                  begin
                     acc <= acc & instr_word[7:0];
                     zero_flag <= (acc & instr_word[7:0]) == 8'h00;
                  end
                  else if (is_literal_add)
                  begin
                     acc <= add_sum[7:0];
                     carry_flag <= add_sum[8];
                     digit_carry_flag <= add_lo[4];
                     zero_flag <= add_sum[7:0] == 8'h00;
                  end
                  else if (is_register_and)
                  begin
                     if (!dest_f)
                        acc <= and_f;
                     zero_flag <= and_f == 8'h00;
                  end
               end
            default:
               state <= ST_RUN;
         endcase
      end
   end

endmodule

// [sim/mcu_mem_model.sv]
`timescale 1ns/1ps
module mcu_mem_model
(
   // Clock
   input wire logic sys_clk,
   // Fetch side
   input wire logic [14:0] program_counter,
   output logic [13:0] instr_word,
   // Data side
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [13:0] prog [0:32767];
   logic [7:0] dmem [0:511];
   logic tog = 1'b0;
   // Top bit kept so slow-region cells stay apart from low ones
   wire [8:0] ix = {mem_addr[15], mem_addr[7:0]};
   initial
   begin
      for (int i = 0; i < 32768; i++)
         prog[i] = 14'h0000;
      for (int i = 0; i < 512; i++)
         dmem[i] = 8'h00;
   end
   assign instr_word = prog[program_counter];
   // Toggles when not read, so a stale value cannot pass
   assign mem_rdata = mem_rd ? dmem[ix] : {8{tog}};
   always @(posedge sys_clk)
   begin
      tog <= ~tog;
      if (mem_wr)
         dmem[ix] <= mem_wdata;
   end
endmodule

// [sim/mcu_decoder_monitor.sv]
`timescale 1ns/1ps
module mcu_decoder_monitor
(
   // Clock and control
   input wire sys_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire busy,
   // Fetch and data
   input wire [13:0] instr_word,
   input wire [6:0] pc_latch_hi,
   input wire [14:0] program_counter,
   input wire [15:0] mem_addr,
   input wire mem_wr,
   input wire [7:0] mem_wdata,
   // Core state
   input wire [7:0] acc,
   input wire [15:0] ptr0,
   input wire carry_flag,
   input wire digit_carry_flag,
   input wire zero_flag,
   input wire timeout_flag,
   input wire powerdown_flag,
   input wire [63:0] pin_direction_reg,
   input wire standby,
   input wire watchdog_clear,
   input wire irq_enable_set
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire run = clk_en && !busy;
   wire [2:0] flg = {carry_flag, digit_carry_flag, zero_flag};
   property p_ptr_add;
      run && instr_word[13:6] == 8'hC4 |=> $stable(flg) && ptr0 ==
         $past(ptr0) + {{10{$past(instr_word[5])}}, $past(instr_word[5:0])};
   endproperty
   a_ptr_add: assert property (p_ptr_add)
      else $error("pointer add result wrong");
   property p_lit_and;
      run && instr_word[13:8] == 6'h39 |=> $stable(carry_flag) &&
         acc == ($past(acc) & $past(instr_word[7:0])) &&
         zero_flag == (acc == 8'h00) && $stable(digit_carry_flag);
   endproperty
   a_lit_and: assert property (p_lit_and)
      else $error("literal and wrong");
   property p_lit_add;
      run && instr_word[13:8] == 6'h3E |=>
         {carry_flag, acc} == {1'b0, $past(acc)} + $past(instr_word[7:0])
         && digit_carry_flag == ({1'b0, $past(acc[3:0])} +
         $past(instr_word[3:0]) > 5'h0F) && zero_flag == (acc == 8'h00);
   endproperty
   a_lit_add: assert property (p_lit_add)
      else $error("literal add wrong");
   property p_jump;
      run && instr_word[13:11] == 3'b101 |=> busy && program_counter ==
         {$past(pc_latch_hi[6:3]), $past(instr_word[10:0])} ##1
         (!busy || !$past(clk_en));
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump target or timing wrong");
   property p_stretch;
      run && instr_word[13:7] == 7'h7E |=> busy == $past(mem_addr[15]);
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("extra cycle wrong");
   property p_store;
      run && instr_word[13:7] == 7'h7F && !mem_addr[15] |->
         mem_wr && mem_wdata == acc ##1 $stable(flg);
   endproperty
   a_store: assert property (p_store)
      else $error("indexed store wrong");
   property p_dir_load;
      run && instr_word[13:3] == 11'h00C && instr_word[2:0] != 3'h3 &&
         instr_word[2:0] != 3'h4 |=> $past(acc) ==
         8'(pin_direction_reg >> {$past(instr_word[2:0]), 3'b000});
   endproperty
   a_dir_load: assert property (p_dir_load)
      else $error("direction load wrong");
   property p_sleep;
      run && instr_word == 14'h0063 |=> standby && timeout_flag &&
         !powerdown_flag;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("standby entry wrong");
   property p_kick;
      run && instr_word == 14'h0064 |=> watchdog_clear && timeout_flag &&
         powerdown_flag ##1 (!watchdog_clear || !$past(clk_en) ||
         $past(instr_word) == 14'h0063 || $past(instr_word) == 14'h0064);
   endproperty
   a_kick: assert property (p_kick)
      else $error("watchdog kick wrong");
   property p_ret_lit;
      run && instr_word[13:8] == 6'h34 |=> busy &&
         acc == $past(instr_word[7:0]);
   endproperty
   a_ret_lit: assert property (p_ret_lit)
      else $error("literal return wrong");
   property p_irq_ret;
      run && instr_word == 14'h0009 |=> busy && irq_enable_set;
   endproperty
   a_irq_ret: assert property (p_irq_ret)
      else $error("interrupt return wrong");
endmodule
bind mcu_control_indirect_op_decoder mcu_decoder_monitor u_mon (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .busy(busy),
   .instr_word(instr_word), .pc_latch_hi(pc_latch_hi),
   .program_counter(program_counter), .mem_addr(mem_addr),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc(acc), .ptr0(ptr0),
   .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
   .zero_flag(zero_flag), .timeout_flag(timeout_flag),
   .powerdown_flag(powerdown_flag), .pin_direction_reg(pin_direction_reg),
   .standby(standby), .watchdog_clear(watchdog_clear),
   .irq_enable_set(irq_enable_set));

// [sim/mcu_control_indirect_op_decoder_test.sv]
`timescale 1ns/1ps
`include "mcu_ctrl_regs.vh"
module mcu_control_indirect_op_decoder_test;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [6:0] pc_latch_hi = 7'h08;
   logic [5:0] bank_sel = 6'h01;
   logic wake_pin = 1'b0;
   wire [14:0] program_counter;
   wire [13:0] instr_word;
   wire [15:0] mem_addr, ptr0, ptr1;
   wire [7:0] mem_wdata, mem_rdata, acc;
   wire [63:0] pin_direction_reg;
   wire mem_rd, mem_wr, carry_flag, digit_carry_flag, zero_flag, busy;
   wire timeout_flag, powerdown_flag, standby, soft_reset_req;
   wire watchdog_clear, irq_enable_set;
   wire [2:0] flg = {carry_flag, digit_carry_flag, zero_flag};
   int error_cnt = 0;
   int num_checks = 0;
   int cyc;
   mcu_control_indirect_op_decoder dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .clk_en(clk_en), .program_counter(program_counter),
      .instr_word(instr_word), .pc_latch_hi(pc_latch_hi),
      .bank_sel(bank_sel), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .acc(acc), .ptr0(ptr0), .ptr1(ptr1), .carry_flag(carry_flag),
      .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
      .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
      .pin_direction_reg(pin_direction_reg), .standby(standby),
      .wake_pin(wake_pin), .soft_reset_req(soft_reset_req),
      .watchdog_clear(watchdog_clear), .irq_enable_set(irq_enable_set),
      .busy(busy));
   mcu_mem_model mem (.sys_clk(sys_clk), .program_counter(program_counter),
      .instr_word(instr_word), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial
   begin
      forever
         #25 sys_clk = ~sys_clk;
   end
   // -------------------------------------------------------
   // Helpers
   // -------------------------------------------------------
   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Places one word at the fetch address, steps until idle
   task automatic exec(logic [13:0] w);
      mem.prog[program_counter] = w;
      cyc = 0;
      do
      begin
         @(posedge sys_clk);
         @(negedge sys_clk);
         cyc++;
      end
      while (busy === 1'b1 && cyc < 8);
   endtask
   task automatic jump_to(logic [14:0] v);
      check("pc", v, program_counter);
      check("cycles", 2, cyc);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // -------------------------------------------------------
   // Tests
   // -------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      check("timeout powerdown", 2'b11, {timeout_flag, powerdown_flag});
      check("dir", {8{8'hFF}}, pin_direction_reg);
      exec(14'h3E8F);
      check("add", 11'h08F, {flg, acc});
      exec(14'h3E71);
      check("add carry", 11'h700, {flg, acc});
      exec(14'h2123);
      jump_to(15'h0923);
      exec(14'h343C);
      jump_to(15'h0003);
      check("ret lit", 11'h73C, {flg, acc});
      exec(14'h390F);
      check("and", 11'h60C, {flg, acc});
      exec(14'h39F0);
      check("and zero", 11'h700, {flg, acc});
      $display("literal test done");
      pc_latch_hi = 7'h10;
      exec(14'h3E05);
      exec(`OP_REL_BRANCH_ACC);
      jump_to(15'd12);
      exec(14'h33FE);
      jump_to(15'd11);
      exec(14'h2FFF);
      jump_to(15'h17FF);
      exec(`OP_CALL_ACC);
      jump_to(15'h1005);
      exec(`OP_RETURN);
      jump_to(15'h1800);
      exec(14'h2001);
      exec(`OP_IRQ_RETURN);
      jump_to(15'h1801);
      exec(`OP_NO_OP);
      check("no op", 15'h1802, program_counter);
      check("no op cycles", 1, cyc);
      $display("branch test done");
      exec(14'h3EA0);
      exec(14'h313F);
      check("ptr0 wrap", 16'hFFFF, ptr0);
      check("ptr cycles", 1, cyc);
      exec(14'h315F);
      check("ptr1", 16'h001F, ptr1);
      check("ptr flags", 3'b000, flg);
      exec(14'h001E);
      check("post inc", 24'h0020A5, {ptr1, mem.dmem[9'h01F]});
      exec(14'h001C);
      check("pre inc", 24'h0021A5, {ptr1, mem.dmem[9'h021]});
      exec(14'h3FFF);
      check("idx st", 24'h0021A5, {ptr1, mem.dmem[9'h020]});
      exec(14'h3900);
      exec(14'h0017);
      check("post dec", 27'h00100A5, {ptr1, flg, acc});
      exec(14'h3F42);
      check("idx ld", 11'h100, {flg, acc});
      exec(14'h0015);
      check("pre dec", 27'h000F8A5, {ptr1, flg, acc});
      mem.dmem[9'h1FF] = 8'h3C;
      exec(14'h3F00);
      check("slow ld", 8'h3C, acc);
      check("slow cycles", 2, cyc);
      exec(14'h3E01);
      exec(14'h001A);
      check("slow st", 24'h00003D, {ptr0, mem.dmem[9'h1FF]});
      check("slow cycles", 2, cyc);
      mem.dmem[9'h0A0] = 8'h0F;
      exec(14'h05A0);
      check("and to f", 16'h3D0D, {acc, mem.dmem[9'h0A0]});
      exec(14'h0520);
      check("and to acc", 11'h00D, {flg, acc});
      $display("indirect test done");
      for (int s = 0; s < 8; s++)
      begin
         if (s != 3 && s != 4)
         begin
            exec(14'h0060 | 14'(s));
            check("dir", 8'h0D, pin_direction_reg[8 * s +: 8]);
         end
      end
      clk_en = 1'b0;
      mem.prog[program_counter] = 14'h3E01;
      repeat (3) @(negedge sys_clk);
      check("frozen", 8'h0D, acc);
      clk_en = 1'b1;
      // Port f=1 reads through pointer 1, still at 001Fh
      exec(14'h0501);
      check("and ind", 11'h005, {flg, acc});
      check("and ind cycles", 1, cyc);
      exec(`OP_KICK);
      check("kick", 3'b111,
         {watchdog_clear, timeout_flag, powerdown_flag});
      exec(`OP_SLEEP);
      check("sleep", 3'b110,
         {standby, timeout_flag, powerdown_flag});
      wake_pin = 1'b1;
      exec(`OP_NO_OP);
      check("woken", 2'b00, {standby, busy});
      exec(`OP_RESET);
      check("sw reset", 1'b1, soft_reset_req);
      $display("system test done");
      finish_test();
   end
   initial
   begin
      #(3000 * 50);
      error_cnt++;
      finish_test();
   end
endmodule
